// [hdl/scc_chopper.sv]
// Fixed-off-time chopper for one H-bridge with blanking and auto decay
`timescale 1ns/100ps
module scc_chopper
  import scc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic positive,
  input wire sccSense_t sense,
  input wire logic [CNT_W-1:0] offCycles,
  output sccChop_t chopState,
  output sccGate_t gate
);

  sccChop_t state_r; // Chopper phase
  logic [CNT_W-1:0] cnt_r; // Blank and off-time counter
  logic offDone; // Off time has elapsed

  assign offDone = (cnt_r >= offCycles - 12'h001);
  assign chopState = state_r;

  // Phase sequencing; losing run parks the bridge at once
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      state_r <= CH_IDLE;
      cnt_r <= '0;
    end else begin
      case (state_r)
        CH_IDLE: begin
          state_r <= CH_BLANK;
          cnt_r <= '0;
        end
        CH_BLANK: begin
          // Comparator ignored here: this is the minimum on time
          if (cnt_r == BLANK_CYC - 12'h001) begin
            state_r <= CH_ON;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 12'h001;
          end
        end
        CH_ON: begin
          if (sense.aboveTrip) begin
            state_r <= CH_SLOW;
          end
        end
        CH_SLOW: begin
          if (sense.zeroCurrent) begin
            state_r <= CH_BLANK;
            cnt_r <= '0;
          end else if (offDone) begin
            state_r <= sense.aboveTrip ? CH_FAST : CH_BLANK;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 12'h001;
          end
        end
        CH_FAST: begin
          if (!sense.aboveTrip) begin
            state_r <= CH_SLOW2;
          end
        end
        CH_SLOW2: begin
          if (sense.zeroCurrent || offDone) begin
            state_r <= CH_BLANK;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 12'h001;
          end
        end
        default: state_r <= CH_IDLE;
      endcase
    end
  end

  // Transistor pattern per phase; the winding sign picks the diagonal
  always_comb begin
    gate = '0;
    case (state_r)
      CH_BLANK, CH_ON: begin
        gate.hsLeft = positive;
        gate.lsRight = positive;
        gate.hsRight = !positive;
        gate.lsLeft = !positive;
      end
      CH_SLOW, CH_SLOW2: begin
        gate.lsLeft = 1'b1;
        gate.lsRight = 1'b1;
      end
      CH_FAST: begin
        gate.hsRight = positive;
        gate.lsLeft = positive;
        gate.hsLeft = !positive;
        gate.lsRight = !positive;
      end
      default: gate = '0;
    endcase
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  slow_entry_a: assert property (run && state_r == CH_ON && sense.aboveTrip
    |=> state_r == CH_SLOW) else $error("trip did not start slow decay");
  fast_entry_a: assert property (run && state_r == CH_SLOW && offDone
    && !sense.zeroCurrent && sense.aboveTrip |=> state_r == CH_FAST)
    else $error("current above trip did not start fast decay");
  blank_length_a: assert property (state_r == CH_ON && $past(state_r) == CH_BLANK
    |-> $past(cnt_r) == BLANK_CYC - 12'h001) else $error("blanking cut short");

endmodule : scc_chopper

// [hdl/scc_sine_lut.sv]
// Winding current percentages for each eighth-step position
`timescale 1ns/100ps
module scc_sine_lut
  import scc_pkg::*;
(
  input wire logic [POS_W-1:0] position,
  output sccPct_t pct
);

  // Signed sine from a quarter-wave table, folded and mirrored
  function automatic logic signed [PCT_W:0] sinAt(input logic [POS_W-1:0] k);
    logic [3:0] m;
    logic [PCT_W-1:0] mag;
    m = k[3:0];
    if (m <= QTR_LAST) begin
      mag = QTR_WAVE[m];
    end else begin
      mag = QTR_WAVE[4'(HALF_WAVE - {1'b0, m})];
    end
    return k[4] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction : sinAt

  // Phase A leads phase B by a quarter turn
  always_comb begin
    pct.a = sinAt(position + QUAD_SHIFT);
    pct.b = sinAt(position);
  end

endmodule : scc_sine_lut

// [hdl/scc_stepper_chopper_control.sv]
// Stepper driver control: translator, choppers, protection and register slave
//
// How it works
// - Each cycle starts with a diagonal pair on
// - Blanking ignores comparator, keeps high side on
// - First trip: high side off, slow decay
// - Zero current ends off time early
// - Off time is 115 ns per kilohm
// - Full-scale current is 71 kilohm over resistor
// - Trip level is step percentage of full scale
// - Still above trip after off: fast decay
// - Below trip in fast decay: slow again
// - Two select bits decode four resolutions
// - Resolutions give 4, 8, 16, 32 positions
// - Undriven resolution selects read as low
// - Sleep stops pump, outputs and inputs
// - Undriven sleep input keeps device asleep
// - Output gate enables bridges and steps
// - Undriven output gate disables bridges, steps
// - Fault flag low while any fault present
// - Overcurrent latches off until sleep toggled
// - Overcurrent seen on both transistor sides
// - Overvoltage disables bridges until supply drops
// - Overcurrent filtered one microsecond first
// - Step rising edge advances one increment
// - Direction level picks forward or backward
// - Reset position is the 45 degree step
`timescale 1ns/100ps
module scc_stepper_chopper_control
  import scc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire sccAxiReq_t axiReq,
  output sccAxiRsp_t axiRsp,
  input wire sccPins_t pins,
  input wire sccPins_t pinsDriven,
  input wire sccSense_t [1:0] sense,
  input wire logic overVoltage,
  input wire logic overTemp,
  input wire logic faultFlagNIn,
  output logic faultFlagNOut,
  output logic faultFlagNOeN,
  output logic chargePumpRun,
  output sccGate_t [1:0] bridgeGate,
  output logic [1:0][MA_W-1:0] tripLevelMa
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin conditioning and mode decode

  sccPins_t pinEff; // Pins after the weak pull-downs
  logic awake; // Not in low-power sleep
  logic enableEff; // Bridges and step edges allowed
  logic dirEff; // Forward when high
  sccRes_t resolution; // Decoded step size
  logic [POS_W-1:0] stepInc; // Index increment per step

  // An undriven pin reads low, like a weak pull-down to ground
  assign pinEff = sccPins_t'(pins & pinsDriven);
  assign awake = pinEff.lowPowerRequestN;
  // In sleep the step and output gate inputs are ignored through this gate
  assign enableEff = awake && pinEff.bridgeOutputGate;
  assign dirEff = pinEff.dir;
  assign resolution = sccRes_t'({pinEff.resSelHigh, pinEff.resSelLow});

  // Increment per step edge over the 32-entry position ring
  always_comb begin
    case (resolution)
      RES_FULL: stepInc = STEP_FULL;
      RES_HALF: stepInc = STEP_HALF;
      RES_QUARTER: stepInc = STEP_QUARTER;
      default: stepInc = STEP_EIGHTH;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Translator

  logic stepPrev_r; // Step level one cycle ago
  logic stepAccept; // Qualified rising edge
  logic [POS_W-1:0] position_r; // Eighth-step index

  // Tracks the step level even while disabled, so enabling never fakes an edge
  always_ff @(posedge clk) begin
    if (rst) begin
      stepPrev_r <= 1'b0;
    end else begin
      stepPrev_r <= pinEff.step;
    end
  end

  assign stepAccept = enableEff && pinEff.step && !stepPrev_r;

  // Position ring wraps naturally at its width
  always_ff @(posedge clk) begin
    if (rst) begin
      position_r <= RESET_POS;
    end else if (stepAccept) begin
      if (dirEff) begin
        position_r <= position_r + stepInc;
      end else begin
        position_r <= position_r - stepInc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-set resistors and derived currents and times

  logic [RES_W-1:0] offRes_r; // Off-time resistor, kilohm
  logic [RES_W-1:0] fsRes_r; // Full-scale resistor, kilohm
  logic [CNT_W-1:0] offCycles; // Off time in clock cycles
  logic [MA_W-1:0] fullScaleMa; // Full-scale current, mA
  sccPct_t pct; // Current percentages at the position

  // Off time rounds up; a zero resistor still gives one cycle
  always_comb begin
    offCycles = CNT_W'((OFF_NS_PER_KOHM * int'(offRes_r) + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS);
    if (offCycles == '0) begin
      offCycles = 12'h001;
    end
  end

  // Register writes clamp the resistor so the divide stays in range
  assign fullScaleMa = MA_W'(FS_MA_KOHM / int'(fsRes_r));

  scc_sine_lut u_lut (
    .position(position_r),
    .pct(pct)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Protection

  logic ocAny; // Any transistor over current
  logic [CNT_W-1:0] ocCount_r; // Persistence counter
  logic ocpLatch_r; // Latched overcurrent shutdown
  logic driveAllowed; // Bridges may switch
  logic faultActive; // Any fault present
  logic faultFlagNOeN_r; // Flag pin released when high
  logic chargePumpRun_r; // Gate drive pump runs

  // Dedicated detectors on both sides, not the chopper comparator
  assign ocAny = sense[0].ocHs || sense[0].ocLs || sense[1].ocHs || sense[1].ocLs;

  // Short spikes below the deglitch time restart the count
  always_ff @(posedge clk) begin
    if (rst || !awake || !ocAny) begin
      ocCount_r <= '0;
    end else if (ocCount_r != OCP_CYC) begin
      ocCount_r <= ocCount_r + 12'h001;
    end
  end

  // Only a sleep cycle or a reset clears the latch
  always_ff @(posedge clk) begin
    if (rst || !awake) begin
      ocpLatch_r <= 1'b0;
    end else if (ocAny && ocCount_r == OCP_CYC - 12'h001) begin
      ocpLatch_r <= 1'b1;
    end
  end

  // Overvoltage clears itself as the supply comparator releases
  assign driveAllowed = enableEff && !ocpLatch_r && !overVoltage && !overTemp;
  assign faultActive = ocpLatch_r || overVoltage || overTemp;

  // Open-drain flag: drive low while a fault stands
  always_ff @(posedge clk) begin
    if (rst) begin
      faultFlagNOeN_r <= 1'b1;
    end else begin
      faultFlagNOeN_r <= !faultActive;
    end
  end

  // Pump stops in sleep
  always_ff @(posedge clk) begin
    if (rst) begin
      chargePumpRun_r <= 1'b0;
    end else begin
      chargePumpRun_r <= awake;
    end
  end

  assign faultFlagNOut = 1'b0;
  assign faultFlagNOeN = faultFlagNOeN_r;
  assign chargePumpRun = chargePumpRun_r;

  ////////////////////////////////////////////////////////////////////////////
  // Two bridges

  sccChop_t chopState [2]; // Chopper phase per bridge
  sccGate_t chopGate [2]; // Ungated transistor pattern
  sccGate_t bridgeGate_r [2]; // Registered gate drive, one process per bridge
  logic [MA_W-1:0] trip_r [2]; // Trip level per bridge, mA

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_bridge
      logic signed [PCT_W:0] pctSigned; // Signed share for this winding
      logic [PCT_W-1:0] pctMag; // Its magnitude

      assign pctSigned = (gi == 0) ? pct.a : pct.b;
      assign pctMag = pctSigned[PCT_W] ? PCT_W'(-pctSigned) : PCT_W'(pctSigned);

      scc_chopper u_chop (
        .clk(clk),
        .rst(rst),
        .run(driveAllowed),
        .positive(!pctSigned[PCT_W]),
        .sense(sense[gi]),
        .offCycles(offCycles),
        .chopState(chopState[gi]),
        .gate(chopGate[gi])
      );

      // Trip level is the step share of full scale, registered for the DAC
      always_ff @(posedge clk) begin
        if (rst) begin
          trip_r[gi] <= '0;
        end else begin
          trip_r[gi] <= MA_W'((32'(fullScaleMa) * 32'(pctMag)) / PCT_FULL);
        end
      end

      // Any disable condition removes drive one edge later
      always_ff @(posedge clk) begin
        if (rst || !driveAllowed) begin
          bridgeGate_r[gi] <= '0;
        end else begin
          bridgeGate_r[gi] <= chopGate[gi];
        end
      end
    end
  endgenerate

  assign bridgeGate = {bridgeGate_r[1], bridgeGate_r[0]};
  assign tripLevelMa = {trip_r[1], trip_r[0]};

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite register slave

  logic awHave_r; // Write address held
  logic [ADDR_W-1:0] awAddr_r;
  logic wHave_r; // Write data held
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;
  logic doWrite; // Both halves present
  logic [31:0] rdNxt; // Read data decode
  logic [1:0] rrNxt; // Read response decode
  sccStatus_t status; // Live status word

  // Channels refuse new items while a response is pending
  assign axiRsp.awready = !awHave_r && !bValid_r;
  assign axiRsp.wready = !wHave_r && !bValid_r;
  assign axiRsp.arready = !rValid_r;
  assign axiRsp.bvalid = bValid_r;
  assign axiRsp.bresp = bResp_r;
  assign axiRsp.rvalid = rValid_r;
  assign axiRsp.rdata = rData_r;
  assign axiRsp.rresp = rResp_r;
  assign doWrite = awHave_r && wHave_r && !bValid_r;

  // Address and data captured in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      awHave_r <= 1'b0;
      awAddr_r <= '0;
      wHave_r <= 1'b0;
      wData_r <= '0;
      wStrb_r <= '0;
    end else if (doWrite) begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
    end else begin
      if (axiReq.awvalid && axiRsp.awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= axiReq.awaddr;
      end
      if (axiReq.wvalid && axiRsp.wready) begin
        wHave_r <= 1'b1;
        wData_r <= axiReq.wdata;
        wStrb_r <= axiReq.wstrb;
      end
    end
  end

  // Register writes and the write response
  always_ff @(posedge clk) begin
    if (rst) begin
      offRes_r <= OFF_RES_RST;
      fsRes_r <= FS_RES_RST;
      bValid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_r <= 1'b1;
      bResp_r <= RESP_OKAY;
      if (awAddr_r == REG_OFF_RES) begin
        if (wStrb_r[0]) begin
          offRes_r <= wData_r[RES_W-1:0];
        end
      end else if (awAddr_r == REG_FS_RES) begin
        if (wStrb_r[0]) begin
          fsRes_r <= (wData_r[RES_W-1:0] < FS_RES_MIN) ? FS_RES_MIN : wData_r[RES_W-1:0];
        end
      end else if (awAddr_r != REG_STATUS && awAddr_r != REG_TRIP) begin
        bResp_r <= RESP_SLVERR;
      end
    end else if (bValid_r && axiReq.bready) begin
      bValid_r <= 1'b0;
    end
  end

  // Status word gathers block state for software
  always_comb begin
    status = '0;
    status.chopB = chopState[1];
    status.chopA = chopState[0];
    status.res = resolution;
    status.pos = position_r;
    status.faultPin = faultFlagNIn;
    status.overTemp = overTemp;
    status.overVoltage = overVoltage;
    status.ocpLatched = ocpLatch_r;
    status.awake = awake;
  end

  // Read decode; unmapped addresses read zero with an error
  always_comb begin
    rdNxt = '0;
    rrNxt = RESP_OKAY;
    if (axiReq.araddr == REG_OFF_RES) begin
      rdNxt = 32'(offRes_r);
    end else if (axiReq.araddr == REG_FS_RES) begin
      rdNxt = 32'(fsRes_r);
    end else if (axiReq.araddr == REG_STATUS) begin
      rdNxt = status;
    end else if (axiReq.araddr == REG_TRIP) begin
      rdNxt = {trip_r[1], trip_r[0]};
    end else begin
      rrNxt = RESP_SLVERR;
    end
  end

  // Read response held until the master takes it
  always_ff @(posedge clk) begin
    if (rst) begin
      rValid_r <= 1'b0;
      rData_r <= '0;
      rResp_r <= RESP_OKAY;
    end else if (axiReq.arvalid && axiRsp.arready) begin
      rValid_r <= 1'b1;
      rData_r <= rdNxt;
      rResp_r <= rrNxt;
    end else if (rValid_r && axiReq.rready) begin
      rValid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sleep_off_a: assert property (!awake |=> !chargePumpRun && bridgeGate == '0
    && $stable(position_r)) else $error("sleep left device active");
  sleep_pull_a: assert property (!pinsDriven.lowPowerRequestN |=> !chargePumpRun)
    else $error("undriven sleep input did not sleep");
  gate_off_a: assert property (!pinEff.bridgeOutputGate |=> bridgeGate == '0
    && $stable(position_r)) else $error("bridges or steps active while gated");
  step_move_a: assert property (stepAccept |=> position_r == ($past(dirEff)
    ? $past(position_r) + $past(stepInc) : $past(position_r) - $past(stepInc)))
    else $error("step edge moved wrong amount");
  full_step_a: assert property (stepAccept && dirEff && resolution == RES_FULL
    |=> position_r == $past(position_r) + STEP_FULL) else $error("full step not 8");
  reset_pos_a: assert property ($fell(rst) |-> position_r == RESET_POS)
    else $error("translator not at 45 degree position");
  ocp_hold_a: assert property (ocpLatch_r && awake |=> ocpLatch_r
    && bridgeGate == '0 && !faultFlagNOeN) else $error("overcurrent latch released");
  ocp_filter_a: assert property ($rose(ocpLatch_r)
    |-> $past(ocCount_r) == OCP_CYC - 12'h001) else $error("overcurrent not filtered");
  ovp_off_a: assert property (overVoltage |=> bridgeGate == '0 && !faultFlagNOeN)
    else $error("overvoltage did not disable bridges");
  flag_release_a: assert property (!faultActive |=> faultFlagNOeN)
    else $error("fault flag held without fault");

  eighth_step_c: cover property (stepAccept && resolution == RES_EIGHTH);
  fast_decay_c: cover property (chopState[0] == CH_FAST ##1 chopState[0] == CH_SLOW2);
  ocp_trip_c: cover property ($rose(ocpLatch_r));
  wake_c: cover property ($rose(awake));

endmodule : scc_stepper_chopper_control

// [include/scc_pkg.sv]
// Shared constants and types for the stepper chopper control block
package scc_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int BLANK_NS = 2000;
  localparam int OCP_DEGLITCH_NS = 1000;
  localparam int OFF_NS_PER_KOHM = 115;
  localparam int CNT_W = 12;
  // Least times round up to whole cycles
  localparam logic [CNT_W-1:0] BLANK_CYC =
    CNT_W'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OCP_CYC =
    CNT_W'((OCP_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Current scaling, percentages in hundredths of a percent
  localparam int FS_MA_KOHM = 71000;
  localparam int PCT_FULL = 10000;
  localparam int PCT_W = 14;
  localparam int MA_W = 16;
  // Translator
  localparam int POS_W = 5;
  localparam logic [POS_W-1:0] RESET_POS = 5'h04;
  localparam logic [POS_W-1:0] STEP_FULL = 5'h08;
  localparam logic [POS_W-1:0] STEP_HALF = 5'h04;
  localparam logic [POS_W-1:0] STEP_QUARTER = 5'h02;
  localparam logic [POS_W-1:0] STEP_EIGHTH = 5'h01;
  localparam logic [POS_W-1:0] QUAD_SHIFT = 5'h08;
  localparam logic [POS_W-1:0] HALF_WAVE = 5'h10;
  localparam logic [3:0] QTR_LAST = 4'h8;
  localparam logic [PCT_W-1:0] QTR_WAVE [0:8] = '{14'h0000, 14'h079F, 14'h0EF3,
    14'h15B4, 14'h1B9F, 14'h207B, 14'h2417, 14'h2650, 14'h2710};
  // Register map
  localparam int ADDR_W = 8;
  localparam int RES_W = 8;
  localparam logic [ADDR_W-1:0] REG_OFF_RES = 8'h00;
  localparam logic [ADDR_W-1:0] REG_FS_RES = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_TRIP = 8'h0C;
  localparam logic [RES_W-1:0] OFF_RES_RST = 8'hC8;
  localparam logic [RES_W-1:0] FS_RES_RST = 8'h47;
  localparam logic [RES_W-1:0] FS_RES_MIN = 8'h02;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Types
  typedef enum logic [1:0] {RES_FULL, RES_HALF, RES_QUARTER, RES_EIGHTH} sccRes_t;
  typedef enum logic [2:0] {CH_IDLE, CH_BLANK, CH_ON, CH_SLOW, CH_FAST, CH_SLOW2} sccChop_t;
  typedef struct packed {logic hsLeft; logic lsLeft; logic hsRight; logic lsRight;} sccGate_t;
  typedef struct packed {logic aboveTrip; logic zeroCurrent; logic ocHs; logic ocLs;} sccSense_t;
  typedef struct packed {
    logic step; logic dir; logic resSelLow; logic resSelHigh;
    logic lowPowerRequestN; logic bridgeOutputGate;
  } sccPins_t;
  typedef struct packed {logic signed [PCT_W:0] a; logic signed [PCT_W:0] b;} sccPct_t;
  typedef struct packed {
    logic [13:0] zero; sccChop_t chopB; sccChop_t chopA; sccRes_t res;
    logic [POS_W-1:0] pos; logic faultPin; logic overTemp; logic overVoltage;
    logic ocpLatched; logic awake;
  } sccStatus_t;
  typedef struct packed {
    logic awvalid; logic [ADDR_W-1:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [ADDR_W-1:0] araddr; logic rready;
  } sccAxiReq_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } sccAxiRsp_t;
endpackage : scc_pkg

// [testbench/scc_motion_ctrl.sv]
// Motion controller model that drives the step and mode pins
`timescale 1ns/100ps
module scc_motion_ctrl
  import scc_pkg::*;
#(parameter int WAKE_CYC = 20)
(
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] cfg,
  input wire logic [1:0] mode,
  output sccPins_t pins
);
  int wakeCnt_r = 0;
  // Shortened wake delay keeps the run brief; steps wait for it after waking,
  // while steps sent to a sleeping device show that it ignores them
  always @(posedge clk) begin
    wakeCnt_r <= mode[1] ? wakeCnt_r + 1 : 0;
    pins <= {go && (!mode[1] || wakeCnt_r > WAKE_CYC) && !pins.step, cfg, mode};
  end
endmodule : scc_motion_ctrl

// [testbench/stepper_chopper_control_bench.sv]
// Self-checking bench for the stepper chopper control block
`timescale 1ns/100ps
module stepper_chopper_control_bench;
  import scc_pkg::*;
  logic clk = 0;
  logic rst = 1;
  sccAxiReq_t axiReq = '{bready: 1, rready: 1, default: 0};
  sccAxiRsp_t axiRsp;
  sccPins_t pins;
  sccPins_t pinsDriven = 6'h3F;
  sccSense_t [1:0] sense = '0;
  logic overVoltage = 0;
  logic overTemp = 0;
  logic [1:0][15:0] tripMa;
  logic go = 0;
  logic [2:0] cfg = 0;
  logic [1:0] mode = 0;
  logic faultOeN;
  logic faultOut;
  logic pump;
  sccGate_t [1:0] gate;
  logic [31:0] rd;
  logic [1:0] rsp;
  int fails = 0;
  int cmp_count = 0;
  always #4 clk = ~clk;
  scc_motion_ctrl u_ctrl (.clk(clk), .go(go), .cfg(cfg), .mode(mode), .pins(pins));
  // Fault pin has a pull-up, so released reads high
  scc_stepper_chopper_control u_dut (.clk(clk), .rst(rst), .axiReq(axiReq),
    .axiRsp(axiRsp), .pins(pins), .pinsDriven(pinsDriven), .sense(sense),
    .overVoltage(overVoltage), .overTemp(overTemp), .faultFlagNIn(faultOeN | faultOut),
    .faultFlagNOut(faultOut), .faultFlagNOeN(faultOeN), .chargePumpRun(pump),
    .bridgeGate(gate), .tripLevelMa(tripMa));
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Write; each channel dropped once taken, bready stays high
  task automatic axW(input logic [7:0] a, input logic [7:0] d);
    axiReq.awaddr <= a;
    axiReq.wdata <= {24'h0, d};
    axiReq.wstrb <= 4'hF;
    axiReq.awvalid <= 1;
    axiReq.wvalid <= 1;
    forever begin
      @(posedge clk);
      if (axiRsp.awready) axiReq.awvalid <= 0;
      if (axiRsp.wready) axiReq.wvalid <= 0;
      if (axiRsp.bvalid) break;
    end
    rsp = axiRsp.bresp;
  endtask : axW
  task automatic axR(input logic [7:0] a);
    axiReq.araddr <= a;
    axiReq.arvalid <= 1;
    forever begin
      @(posedge clk);
      if (axiRsp.arready) axiReq.arvalid <= 0;
      if (axiRsp.rvalid) break;
    end
    rd = axiRsp.rdata;
    rsp = axiRsp.rresp;
  endtask : axR
  // One step pulse with {dir, low, high} set up ahead of it
  task automatic stp(input logic [2:0] c);
    cfg <= c;
    cyc(2);
    go <= 1;
    cyc(2);
    go <= 0;
    cyc(3);
    axR(REG_STATUS);
  endtask : stp
  task automatic t_regs();
    axR(REG_STATUS);
    chk(rd[9:5], 4);
    axR(REG_FS_RES);
    chk(rd, 32'h47);
    axR(8'h10);
    chk({rsp, rd}, {RESP_SLVERR, 32'h0});
    axW(8'h10, 8'h01);
    chk(rsp, RESP_SLVERR);
    axW(REG_OFF_RES, 8'h08);
    axR(REG_OFF_RES);
    chk(rd, 32'h08);
  endtask : t_regs
  // Backward full step wraps, then every resolution forward
  task automatic t_steps();
    mode <= 2'h3;
    cyc(30);
    stp(3'h0);
    chk(rd[9:5], 28);
    axR(REG_TRIP);
    chk(rd, 32'h02C302C3);
    for (int r = 0; r < 4; r++) begin
      stp({1'h1, r[0], r[1]});
      chk(rd[11:5], {r[1:0], 5'(28 + 16 - (8 >> r))});
    end
    axR(REG_TRIP);
    chk(rd, 32'h033F022B);
    // 71000 over 142 kohm gives a 500 mA full scale
    axW(REG_FS_RES, 8'h8E);
    axR(REG_TRIP);
    chk(tripMa, 32'h019F0115);
  endtask : t_steps
  // Gated, undriven gate, asleep, undriven sleep: step dropped
  task automatic t_gate();
    logic [5:0] dm [4] = '{6'h3F, 6'h3E, 6'h3F, 6'h3D};
    logic [1:0] md [4] = '{2'h2, 2'h3, 2'h1, 2'h3};
    for (int i = 0; i < 4; i++) begin
      mode <= md[i];
      pinsDriven <= dm[i];
      stp(3'h7);
      chk({rd[9:5], gate, pump}, {5'd11, 8'h0, i < 2});
      mode <= 2'h3;
      pinsDriven <= 6'h3F;
      cyc(30);
    end
    pinsDriven <= 6'h33;
    stp(3'h7);
    chk(rd[9:5], 19);
    pinsDriven <= 6'h3F;
  endtask : t_gate
  task automatic t_chop();
    cyc(300);
    axR(REG_STATUS);
    chk({rd[14:12], gate[0] == 4'h9 || gate[0] == 4'h6}, 5);
    sense[0].aboveTrip <= 1;
    cyc(100);
    axR(REG_STATUS);
    chk({rd[14:12], gate[0]}, 7'h35);
    cyc(20);
    axR(REG_STATUS);
    chk(rd[14:12], 4);
    sense[0].aboveTrip <= 0;
    cyc(1);
    axR(REG_STATUS);
    chk(rd[14:12], 5);
    sense[0].zeroCurrent <= 1;
    cyc(1);
    axR(REG_STATUS);
    chk(rd[14:12], 1);
    sense[0] <= 4'h8;
    cyc(100);
    axR(REG_STATUS);
    chk({rd[14:12], gate[0] == 4'h9 || gate[0] == 4'h6}, 3);
    sense[0] <= 0;
  endtask : t_chop
  // Short overcurrent is filtered, long one latches until sleep
  task automatic t_prot();
    sense[1].ocHs <= 1;
    cyc(100);
    sense[1].ocHs <= 0;
    cyc(3);
    chk(faultOeN, 1);
    sense[0].ocLs <= 1;
    cyc(130);
    sense[0].ocLs <= 0;
    cyc(10);
    chk({faultOeN, gate}, 0);
    axR(REG_STATUS);
    chk(rd[4:0], 5'h03);
    mode <= 2'h1;
    cyc(3);
    mode <= 2'h3;
    cyc(30);
    chk(faultOeN, 1);
    overVoltage <= 1;
    cyc(3);
    chk({faultOeN, gate}, 0);
    overVoltage <= 0;
    cyc(3);
    chk({faultOeN, gate[0] != 4'h0}, 2'h3);
    overTemp <= 1;
    cyc(3);
    chk({faultOeN, gate}, 0);
    overTemp <= 0;
    cyc(3);
    chk(faultOeN, 1);
  endtask : t_prot
  task automatic test_done();
    $display("fails %0d compares %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  initial begin
    cyc(5);
    rst <= 0;
    cyc(1);
    t_regs();
    t_steps();
    t_gate();
    t_chop();
    t_prot();
    test_done();
  end
  // Watchdog well beyond the roughly one thousand cycles the tests need
  initial begin
    cyc(20000);
    fails++;
    test_done();
  end
endmodule : stepper_chopper_control_bench
